// ### ppc_pkg.sv
// package: register map, widths and pin carriers for the port pin control block
package ppc_pkg;
  localparam int PPC_AW = 4;
  localparam int PPC_DW = 8;
  // register offsets, chosen locally; one byte register per address
  localparam logic [3:0] PPC_OFS_PWM_PULL_EN = 4'h0;
  localparam logic [3:0] PPC_OFS_PWM_PULL_POL = 4'h1;
  localparam logic [3:0] PPC_OFS_FLT_DATA = 4'h2;
  localparam logic [3:0] PPC_OFS_FLT_LEVEL = 4'h3;
  localparam logic [3:0] PPC_OFS_FLT_DIR = 4'h4;
  localparam logic [3:0] PPC_OFS_FLT_RDRV = 4'h5;
  localparam logic [3:0] PPC_OFS_FLT_PULL_EN = 4'h6;
  localparam logic [3:0] PPC_OFS_FLT_PULL_POL = 4'h7;
  localparam logic [3:0] PPC_OFS_SER_DATA = 4'h8;
  localparam logic [3:0] PPC_OFS_SER_LEVEL = 4'h9;
  localparam logic [3:0] PPC_OFS_SER_DIR = 4'ha;
  // implemented bit masks
  localparam logic [7:0] PPC_PWM_MASK = 8'h3f;
  localparam logic [7:0] PPC_FLT_MASK = 8'h7f;
  localparam logic [7:0] PPC_SER_MASK = 8'hff;
  // reset values
  localparam logic [7:0] PPC_RST_ZERO = 8'h00;
  localparam logic [7:0] PPC_RST_PULL_EN = 8'h00;
  // serial port pin positions, then fault and sense input counts of the fault port
  localparam int PPC_SPI_LO = 4;
  localparam int PPC_S1_TX = 3;
  localparam int PPC_S1_RX = 2;
  localparam int PPC_S0_TX = 1;
  localparam int PPC_S0_RX = 0;
  localparam int PPC_FAULT_N = 4;
  localparam int PPC_SENSE_N = 3;

  // pad controls for one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] reduced;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } ppc_pad_s;

  // serial peripheral enables and drives
  typedef struct packed {
    logic spi_en;
    logic [3:0] spi_oe;
    logic [3:0] spi_out;
    logic s1_tx_en;
    logic s1_rx_en;
    logic s1_tx;
    logic s0_tx_en;
    logic s0_rx_en;
    logic s0_tx;
  } ppc_ser_s;
endpackage : ppc_pkg

// ### ppc_port_pin_control.sv
// port pin control: pwm-port pulls, fault port, serial port data and direction
//
// Behaviour
// - pull enable 0 turns pull device off, 1 turns a pull device on.
// - fault and pwm port pull enable ignored while pin is output.
// - polarity acts only with direction input and pull enable set.
// - polarity 0 pulls up, 1 pulls down; pwm bits 5:0, fault 6:0.
// - motor pwm takes fault-port pins over, making them inputs.
// - fault pins 3:0 feed fault inputs, pins 6:4 feed sense inputs.
// - all fault-port pins are high-impedance inputs during reset.
// - data read gives stored bit for outputs, pin level for inputs.
// - pin level registers read live pins and ignore writes.
// - enabled pwm input forces pin input; direction regains control when off.
// - direction 0 input, 1 output; fault bits 6:0, serial 7:0.
// - reduced drive 0 full strength, 1 asserts reduced pad control.
// - reduced drive has no effect on input pins.
// - spi and both serial channels take priority on serial port pins.
// - spi enabled puts its four signals on pins 7:4, ignoring direction.
// - second serial transmit on pin 3, receive on pin 2, ignoring direction.
// - first serial transmit on pin 1, receive on pin 0, ignoring direction.
// - with peripherals off the direction bit again controls the pin.
// - serial-port pins are high-impedance inputs during reset unless spi or a serial transmit enable drives them.
// - fault data register resets to zero; bit 7 reserved, reads zero.
`timescale 1ns/10ps

module ppc_port_pin_control
  import ppc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [PPC_AW-1:0] addr,
  input wire logic [PPC_DW-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [PPC_DW-1:0] rdata,
  input wire logic [7:0] pwm_pin_dir,
  output logic [7:0] pwm_pull_up,
  output logic [7:0] pwm_pull_down,
  input wire logic [7:0] flt_pin_in,
  output ppc_pad_s flt_pad,
  input wire logic [PPC_FAULT_N+PPC_SENSE_N-1:0] pwm_func_en,
  output logic [PPC_FAULT_N-1:0] pwm_fault_in,
  output logic [PPC_SENSE_N-1:0] pwm_sense_in_n,
  input wire logic [7:0] ser_pin_in,
  output ppc_pad_s ser_pad,
  input ppc_ser_s ser_periph,
  output logic [3:0] spi_in,
  output logic s1_rx,
  output logic s0_rx
);

  // pull device decode shared by both pulled ports
  function automatic logic [15:0] ppc_pull(input logic [7:0] dir, input logic [7:0] en,
                                           input logic [7:0] pol, input logic [7:0] mask);
    logic [7:0] act;
    act = ~dir & en & mask;
    return {act & ~pol, act & pol};
  endfunction : ppc_pull

  // data read: stored bit where output, live pin where input
  function automatic logic [7:0] ppc_rd(input logic [7:0] dir, input logic [7:0] dat,
                                        input logic [7:0] pin, input logic [7:0] mask);
    return ((dir & dat) | (~dir & pin)) & mask;
  endfunction : ppc_rd

  logic [7:0] pwm_pull_en_reg;
  logic [7:0] pwm_pull_pol_reg;
  logic [7:0] flt_data_reg;
  logic [7:0] flt_dir_reg;
  logic [7:0] flt_rdrv_reg;
  logic [7:0] flt_pull_en_reg;
  logic [7:0] flt_pull_pol_reg;
  logic [7:0] ser_data_reg;
  logic [7:0] ser_dir_reg;
  logic [7:0] flt_dir_eff;
  logic [7:0] ser_dir_eff;
  logic [7:0] ser_out_eff;
  logic [7:0] ser_own;
  logic [7:0] rdata_next;
  logic [15:0] pwm_pull;
  logic [15:0] flt_pull;

  // configuration registers; a write lands on the next edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwm_pull_en_reg <= PPC_RST_PULL_EN;
      pwm_pull_pol_reg <= PPC_RST_ZERO;
      flt_rdrv_reg <= PPC_RST_ZERO;
      flt_pull_en_reg <= PPC_RST_PULL_EN;
      flt_pull_pol_reg <= PPC_RST_ZERO;
    end
    else if (wr_en)
    begin
      case (addr)
        PPC_OFS_PWM_PULL_EN: pwm_pull_en_reg <= wdata & PPC_PWM_MASK;
        PPC_OFS_PWM_PULL_POL: pwm_pull_pol_reg <= wdata & PPC_PWM_MASK;
        PPC_OFS_FLT_RDRV: flt_rdrv_reg <= wdata & PPC_FLT_MASK;
        PPC_OFS_FLT_PULL_EN: flt_pull_en_reg <= wdata & PPC_FLT_MASK;
        PPC_OFS_FLT_PULL_POL: flt_pull_pol_reg <= wdata & PPC_FLT_MASK;
        default: ;
      endcase
    end
  end

  // fault port data and direction; zero direction keeps pins input in reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flt_data_reg <= PPC_RST_ZERO;
      flt_dir_reg <= PPC_RST_ZERO;
    end
    else if (wr_en)
    begin
      if (addr == PPC_OFS_FLT_DATA)
        flt_data_reg <= wdata & PPC_FLT_MASK;
      if (addr == PPC_OFS_FLT_DIR)
        flt_dir_reg <= wdata & PPC_FLT_MASK;
    end
  end

  // serial port data and direction
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ser_data_reg <= PPC_RST_ZERO;
      ser_dir_reg <= PPC_RST_ZERO;
    end
    else if (wr_en)
    begin
      if (addr == PPC_OFS_SER_DATA)
        ser_data_reg <= wdata & PPC_SER_MASK;
      if (addr == PPC_OFS_SER_DIR)
        ser_dir_reg <= wdata & PPC_SER_MASK;
    end
  end

  // pwm port pulls; direction comes from the pwm port outside this block
  assign pwm_pull = ppc_pull(pwm_pin_dir, pwm_pull_en_reg, pwm_pull_pol_reg, PPC_PWM_MASK);
  assign pwm_pull_up = pwm_pull[15:8];
  assign pwm_pull_down = pwm_pull[7:0];

  // fault port: motor pwm function forces input, direction ignored meanwhile
  assign flt_dir_eff = flt_dir_reg & ~{1'b0, pwm_func_en} & PPC_FLT_MASK;
  assign flt_pull = ppc_pull(flt_dir_eff, flt_pull_en_reg, flt_pull_pol_reg, PPC_FLT_MASK);
  assign flt_pad.out = flt_data_reg & flt_dir_eff;
  assign flt_pad.oe = flt_dir_eff;
  assign flt_pad.reduced = flt_rdrv_reg & flt_dir_eff;
  assign flt_pad.pull_up = flt_pull[15:8];
  assign flt_pad.pull_down = flt_pull[7:0];

  // pins always feed the pwm inputs; the module ignores them unless enabled
  assign pwm_fault_in = flt_pin_in[PPC_FAULT_N-1:0];
  assign pwm_sense_in_n = flt_pin_in[PPC_FAULT_N+PPC_SENSE_N-1:PPC_FAULT_N];

  // serial port ownership: each function claims only its own pins; spi claims all four of 7:4
  assign ser_own = {{4{ser_periph.spi_en}}, ser_periph.s1_tx_en, ser_periph.s1_rx_en,
                    ser_periph.s0_tx_en, ser_periph.s0_rx_en};

  // effective direction and output mux; peripherals override direction bits
  always_comb
  begin
    ser_dir_eff = ser_dir_reg & ~ser_own;
    ser_out_eff = ser_data_reg;
    if (ser_periph.spi_en)
    begin
      ser_dir_eff[7:PPC_SPI_LO] = ser_periph.spi_oe;
      ser_out_eff[7:PPC_SPI_LO] = ser_periph.spi_out;
    end
    if (ser_periph.s1_tx_en)
    begin
      ser_dir_eff[PPC_S1_TX] = 1'b1;
      ser_out_eff[PPC_S1_TX] = ser_periph.s1_tx;
    end
    if (ser_periph.s0_tx_en)
    begin
      ser_dir_eff[PPC_S0_TX] = 1'b1;
      ser_out_eff[PPC_S0_TX] = ser_periph.s0_tx;
    end
  end

  // serial pads; this port has no reduced drive or pulls in this block
  assign ser_pad.out = ser_out_eff & ser_dir_eff;
  assign ser_pad.oe = ser_dir_eff;
  assign ser_pad.reduced = PPC_RST_ZERO;
  assign ser_pad.pull_up = PPC_RST_ZERO;
  assign ser_pad.pull_down = PPC_RST_ZERO;

  // peripheral inputs taken straight from the pins
  assign spi_in = ser_pin_in[7:PPC_SPI_LO];
  assign s1_rx = ser_pin_in[PPC_S1_RX];
  assign s0_rx = ser_pin_in[PPC_S0_RX];

  // read decode; unmapped offsets read zero
  always_comb
  begin
    rdata_next = PPC_RST_ZERO;
    case (addr)
      PPC_OFS_PWM_PULL_EN: rdata_next = pwm_pull_en_reg;
      PPC_OFS_PWM_PULL_POL: rdata_next = pwm_pull_pol_reg;
      PPC_OFS_FLT_DATA: rdata_next = ppc_rd(flt_dir_eff, flt_data_reg, flt_pin_in,
                                            PPC_FLT_MASK);
      PPC_OFS_FLT_LEVEL: rdata_next = flt_pin_in & PPC_FLT_MASK;
      PPC_OFS_FLT_DIR: rdata_next = flt_dir_reg;
      PPC_OFS_FLT_RDRV: rdata_next = flt_rdrv_reg;
      PPC_OFS_FLT_PULL_EN: rdata_next = flt_pull_en_reg;
      PPC_OFS_FLT_PULL_POL: rdata_next = flt_pull_pol_reg;
      PPC_OFS_SER_DATA: rdata_next = ppc_rd(ser_dir_eff, ser_data_reg, ser_pin_in,
                                            PPC_SER_MASK);
      PPC_OFS_SER_LEVEL: rdata_next = ser_pin_in;
      PPC_OFS_SER_DIR: rdata_next = ser_dir_reg;
      default: rdata_next = PPC_RST_ZERO;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= PPC_RST_ZERO;
    else if (rd_en)
      rdata <= rdata_next;
    else
      rdata <= PPC_RST_ZERO;
  end

endmodule : ppc_port_pin_control

// ### ppc_pin_model.sv
// pin model: pad drive, pulls and outside level resolved to the pin
`timescale 1ns/10ps
module ppc_pin_model
  import ppc_pkg::*;
(
  input wire ppc_pad_s pad,
  input wire logic [7:0] ext,
  output logic [7:0] pin
);
  // a released pin takes its pull, else the outside level, never a stale drive
  assign pin = (pad.oe & pad.out) | (~pad.oe & (pad.pull_up | (~pad.pull_down & ext)));
endmodule : ppc_pin_model

// ### ppc_port_pin_control_chk.sv
// checker: override, pull, drive and write timing of the port block
`timescale 1ns/10ps
module ppc_port_pin_control_chk
  import ppc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [PPC_AW-1:0] addr,
  input wire logic [PPC_DW-1:0] wdata,
  input wire logic wr_en,
  input wire logic [7:0] pwm_pin_dir,
  input wire logic [7:0] pwm_pull_up,
  input wire logic [7:0] pwm_pull_down,
  input wire logic [7:0] flt_pin_in,
  input wire ppc_pad_s flt_pad,
  input wire logic [PPC_FAULT_N+PPC_SENSE_N-1:0] pwm_func_en,
  input wire logic [PPC_FAULT_N-1:0] pwm_fault_in,
  input wire ppc_pad_s ser_pad,
  input wire ppc_ser_s ser_periph
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // direction write, seen on the pads one cycle later
  sequence s_dir_wr;
    wr_en && addr == PPC_OFS_FLT_DIR;
  endsequence
  a_flt_override: assert property ((flt_pad.oe[6:0] & pwm_func_en) == 7'h00)
    else $error("fault pin driven under pwm input");
  a_dir_write: assert property (s_dir_wr |=>
    flt_pad.oe[6:0] == ($past(wdata[6:0]) & ~pwm_func_en)) else $error("direction write lost");
  a_fault_feed: assert property (pwm_fault_in == flt_pin_in[3:0])
    else $error("fault inputs not fed");
  a_pwm_pull: assert property (((pwm_pull_up | pwm_pull_down) & pwm_pin_dir) == 8'h00)
    else $error("pull on pwm output");
  a_rdrv_input: assert property ((flt_pad.reduced & ~flt_pad.oe) == 8'h00)
    else $error("reduced drive on input");
  a_spi_pins: assert property (ser_periph.spi_en |-> ser_pad.oe[7:4] == ser_periph.spi_oe)
    else $error("spi direction lost");
  a_second_async_serial_tx: assert property (ser_periph.s1_tx_en |-> ser_pad.oe[3] && ser_pad.out[3] == ser_periph.s1_tx)
    else $error("second transmit lost");
  a_first_async_serial_rx: assert property (ser_periph.s0_rx_en |-> !ser_pad.oe[0])
    else $error("first receive pin driven");
endmodule : ppc_port_pin_control_chk

bind ppc_port_pin_control ppc_port_pin_control_chk u_chk (.*);

// ### tb_port_pin_control_pqs.sv
// testbench: random registers, peripherals and pins against derived expectations
`timescale 1ns/10ps
module tb_port_pin_control_pqs import ppc_pkg::*;;
  logic clk, nrst, wr_en, rd_en, s1_rx, s0_rx;
  logic [3:0] addr, spi_in, pwm_fault_in;
  logic [7:0] wdata, rdata, pwm_pin_dir, pwm_pull_up, pwm_pull_down, flt_pin_in, ser_pin_in;
  logic [7:0] ext_f, ext_s, ef, es, eo, v;
  logic [7:0] rv [0:10];
  logic [6:0] pwm_func_en;
  logic [2:0] pwm_sense_in_n;
  ppc_pad_s flt_pad, ser_pad;
  ppc_ser_s ser_periph;
  int errors = 0, cmp_count = 0;
  always #2 clk = ~clk;
  ppc_port_pin_control dut (.*);
  ppc_pin_model u_fpin (.pad(flt_pad), .ext(ext_f), .pin(flt_pin_in));
  ppc_pin_model u_spin (.pad(ser_pad), .ext(ext_s), .pin(ser_pin_in));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 v = rdata;
  endtask : rd
  function automatic logic [7:0] exp_rd(int j);
    case (j)
      0, 1: return rv[j] & PPC_PWM_MASK;
      2: return ((ef & rv[2]) | (~ef & flt_pin_in)) & PPC_FLT_MASK;
      3: return flt_pin_in & PPC_FLT_MASK;
      4, 5, 6, 7: return rv[j] & PPC_FLT_MASK;
      8: return (es & rv[8]) | (~es & ser_pin_in);
      9: return ser_pin_in;
      10: return rv[10];
      default: return 8'h00;
    endcase
  endfunction : exp_rd
  task complete_run;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // hang guard, several times the expected run
  initial
  begin
    #40000;
    errors++;
    complete_run();
  end
  // first pass has every pwm input on, then peripherals all off and all on
  initial
  begin
    {clk, nrst, wr_en, rd_en, addr, wdata, pwm_pin_dir, pwm_func_en, ser_periph} = '0;
    {ext_f, ext_s} = 16'h5aa5;
    void'($urandom(32'h135e));
    repeat (2) @(posedge clk);
    #1 chk("flt_oe_rst", 8'h00, flt_pad.oe);
    chk("ser_oe_rst", 8'h00, ser_pad.oe);
    @(posedge clk);
    nrst <= 1'h1;
    wr(PPC_OFS_FLT_DIR, 8'hff);
    rd(PPC_OFS_FLT_DATA);
    chk("flt_data_rst", 8'h00, v);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      pwm_func_en <= (i == 0) ? 7'h7f : 7'($urandom);
      ser_periph <= (i == 1 || i == 2) ? {15{i[1]}} : 15'($urandom);
      pwm_pin_dir <= 8'($urandom);
      ext_f <= 8'($urandom);
      ext_s <= 8'($urandom);
      for (int j = 0; j < 11; j++)
      begin
        rv[j] = 8'($urandom);
        wr(4'(j), rv[j]);
      end
      ef = rv[4] & ~{1'h0, pwm_func_en} & PPC_FLT_MASK;
      es = ser_periph.spi_en ? {ser_periph.spi_oe, rv[10][3:0]} : rv[10];
      es[3:0] = (es[3:0] | {ser_periph.s1_tx_en, 1'h0, ser_periph.s0_tx_en, 1'h0})
        & ~{1'h0, ser_periph.s1_rx_en, 1'h0, ser_periph.s0_rx_en};
      eo = ser_periph.spi_en ? {ser_periph.spi_out, rv[8][3:0]} : rv[8];
      eo[3] = ser_periph.s1_tx_en ? ser_periph.s1_tx : eo[3];
      eo[1] = ser_periph.s0_tx_en ? ser_periph.s0_tx : eo[1];
      for (int j = 0; j < 12; j++)
      begin
        rd(j == 11 ? 4'hf : 4'(j));
        chk("read", exp_rd(j), v);
      end
      chk("flt_oe", ef, flt_pad.oe);
      chk("flt_out", rv[2] & ef, flt_pad.out);
      chk("flt_up", ~ef & rv[6] & ~rv[7] & PPC_FLT_MASK, flt_pad.pull_up);
      chk("flt_dn", ~ef & rv[6] & rv[7] & PPC_FLT_MASK, flt_pad.pull_down);
      chk("flt_red", rv[5] & ef, flt_pad.reduced);
      chk("pwm_up", ~pwm_pin_dir & rv[0] & ~rv[1] & PPC_PWM_MASK, pwm_pull_up);
      chk("pwm_dn", ~pwm_pin_dir & rv[0] & rv[1] & PPC_PWM_MASK, pwm_pull_down);
      chk("ser_oe", es, ser_pad.oe);
      chk("ser_out", eo & es, ser_pad.out);
      chk("ser_in", ser_pin_in & 8'hf5, {spi_in, 1'h0, s1_rx, 1'h0, s0_rx});
      chk("sense_in", flt_pin_in[6:4], {5'h00, pwm_sense_in_n});
    end
    complete_run();
  end
endmodule : tb_port_pin_control_pqs
